//--- include/pcg_cfg.svh
// Offsets, field positions, reset values and unit indices of the clock gating block.
`ifndef PCG_CFG_SVH
`define PCG_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PCG_ADDR_W 12
`define PCG_OFS_RUN_CFG 12'h060
`define PCG_OFS_RUN_FIRST 12'h100
`define PCG_OFS_RUN_SECOND 12'h108
`define PCG_OFS_SLP_FIRST 12'h110
`define PCG_OFS_SLP_SECOND 12'h118
`define PCG_OFS_DSL_FIRST 12'h124
`define PCG_OFS_DSL_SECOND 12'h128
`define PCG_OFS_IRQ_STAT 12'h150
`define PCG_OFS_IRQ_EN 12'h154
`define PCG_OFS_IRQ_CLR 12'h158
`define PCG_OFS_GATE_STAT 12'h15c

// ----------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------
`define PCG_SECOND_MASK 32'h5000007f
`define PCG_FIRST_MASK 32'h00001013
`define PCG_CFG_MASK 32'h00000001
`define PCG_ACG_BIT 0
`define PCG_GATE_RST 32'h00000000
`define PCG_SEC_PHY_BIT 30
`define PCG_SEC_MAC_BIT 28
`define PCG_FST_TWI_BIT 12
`define PCG_FST_SSI_BIT 4
`define PCG_FST_AS1_BIT 1
`define PCG_FST_AS0_BIT 0
`define PCG_IRQ_FAULT_BIT 0
`define PCG_IRQ_MODE_BIT 1
`define PCG_IRQ_W 2

// ----------------------------------------------------------------
// Gated unit indices: ports A..G are 0..6
// ----------------------------------------------------------------
`define PCG_UNITS 13
`define PCG_U_MAC 7
`define PCG_U_PHY 8
`define PCG_U_AS0 9
`define PCG_U_AS1 10
`define PCG_U_SSI 11
`define PCG_U_TWI 12

`endif

//--- include/pcg_pkg.sv
// Types shared by the clock gating block and its bench.
`default_nettype none
package pcg_pkg;

    // Power state of the core, Gray coded along run, sleep, deep-sleep.
    typedef enum logic [1:0] {
        PCG_MODE_RUN = 2'h0,
        PCG_MODE_SLEEP = 2'h1,
        PCG_MODE_DEEP = 2'h3
    } pcg_mode_e;

    typedef logic [31:0] pcg_word_t;

endpackage
`default_nettype wire

//--- logic/pcg_top.sv
// Peripheral clock gating block with register port, fault detection and interrupt.
//
// Overview of operation
// - Each gate bit at 1 clocks and enables its unit, at 0 stops the clock and holds it disabled.
// - An access to a unit whose gate leaves it unclocked is answered with a bus fault.
// - After reset every gate bit is 0 and the run-mode second gate register reads 0.
// - Bit 30 of the run-mode second gate register gates the Ethernet PHY unit.
// - Bit 28 of the run-mode second gate register gates the Ethernet MAC unit.
// - Bits 6 to 0 of the run-mode second gate register gate ports G down to A.
// - Reserved bits are read-only and read as 0.
// - Bit 12 of the deep-sleep first gate register gates two-wire unit 0 in deep-sleep.
// - Bit 4 of the deep-sleep first gate register gates sync serial unit 0 in deep-sleep.
// - Bits 1 and 0 of the deep-sleep first gate register gate async serial units 1 and 0.
// - Run, sleep and deep-sleep each apply their own independent set of gate bits.
// - Sleep and deep-sleep sets apply only while the automatic gating bit is set.
`include "pcg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pcg_top (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [`PCG_ADDR_W-1:0] addr_i,
    input wire pcg_pkg::pcg_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output pcg_pkg::pcg_word_t rdata_o,
    input wire pcg_pkg::pcg_mode_e power_mode_i,
    input wire logic [`PCG_UNITS-1:0] unit_sel_i,
    input wire logic unit_access_i,
    output logic bus_fault_o,
    output logic [`PCG_UNITS-1:0] unit_en_o,
    output logic [`PCG_UNITS-1:0] unit_clk_o,
    output logic irq_o
);
    import pcg_pkg::*;

    // ----------------------------------------------------------------
    // Gate vector builder
    // ----------------------------------------------------------------

    // Gathers the unit gate bits of a first and second register pair.
    function automatic logic [`PCG_UNITS-1:0] pcg_gates(input pcg_word_t first,
                                                        input pcg_word_t second);
        logic [`PCG_UNITS-1:0] g;
        g = '0;
        g[6:0] = second[6:0];
        g[`PCG_U_MAC] = second[`PCG_SEC_MAC_BIT];
        g[`PCG_U_PHY] = second[`PCG_SEC_PHY_BIT];
        g[`PCG_U_AS0] = first[`PCG_FST_AS0_BIT];
        g[`PCG_U_AS1] = first[`PCG_FST_AS1_BIT];
        g[`PCG_U_SSI] = first[`PCG_FST_SSI_BIT];
        g[`PCG_U_TWI] = first[`PCG_FST_TWI_BIT];
        return g;
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    pcg_word_t run_clock_config_reg;
    pcg_word_t run_gate_ctrl_first_reg;
    pcg_word_t run_gate_ctrl_second_reg;
    pcg_word_t sleep_gate_ctrl_first_reg;
    pcg_word_t sleep_gate_ctrl_second_reg;
    pcg_word_t deep_sleep_gate_ctrl_first_reg;
    pcg_word_t deep_sleep_gate_ctrl_second_reg;
    logic [`PCG_IRQ_W-1:0] irq_stat_reg;
    logic [`PCG_IRQ_W-1:0] irq_stat_next;
    logic [`PCG_IRQ_W-1:0] irq_en_reg;
    logic [`PCG_UNITS-1:0] gate_en_reg;
    logic [`PCG_UNITS-1:0] gate_en_next;
    logic [`PCG_UNITS-1:0] gate_lat_reg;
    pcg_mode_e applied_mode_reg;
    pcg_mode_e applied_mode_next;
    pcg_word_t rdata_reg;
    pcg_word_t rdata_next;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------

    // One strobe per writable register.
    wire wr_cfg = wr_i && (addr_i == `PCG_OFS_RUN_CFG);
    wire wr_run1 = wr_i && (addr_i == `PCG_OFS_RUN_FIRST);
    wire wr_run2 = wr_i && (addr_i == `PCG_OFS_RUN_SECOND);
    wire wr_slp1 = wr_i && (addr_i == `PCG_OFS_SLP_FIRST);
    wire wr_slp2 = wr_i && (addr_i == `PCG_OFS_SLP_SECOND);
    wire wr_dsl1 = wr_i && (addr_i == `PCG_OFS_DSL_FIRST);
    wire wr_dsl2 = wr_i && (addr_i == `PCG_OFS_DSL_SECOND);
    wire wr_ien = wr_i && (addr_i == `PCG_OFS_IRQ_EN);
    wire wr_iclr = wr_i && (addr_i == `PCG_OFS_IRQ_CLR);

    // Masked write data; reserved positions are never stored.
    // reserved bits dropped
    wire pcg_word_t wd_first = wdata_i & `PCG_FIRST_MASK;
    wire pcg_word_t wd_second = wdata_i & `PCG_SECOND_MASK;
    wire pcg_word_t wd_cfg = wdata_i & `PCG_CFG_MASK;

    // ----------------------------------------------------------------
    // Gate selection
    // ----------------------------------------------------------------

    // Automatic gating enable from the run clock configuration.
    wire auto_gating_select = run_clock_config_reg[`PCG_ACG_BIT];

    // Gate sets of each power state.
    // independent sets
    wire [`PCG_UNITS-1:0] run_gates = pcg_gates(run_gate_ctrl_first_reg,
                                                run_gate_ctrl_second_reg);
    wire [`PCG_UNITS-1:0] slp_gates = pcg_gates(sleep_gate_ctrl_first_reg,
                                                sleep_gate_ctrl_second_reg);
    wire [`PCG_UNITS-1:0] dsl_gates = pcg_gates(deep_sleep_gate_ctrl_first_reg,
                                                deep_sleep_gate_ctrl_second_reg);

    // Mode actually applied: the run set unless automatic gating is on.
    // auto gating qualifies
    always_comb begin
        applied_mode_next = PCG_MODE_RUN;
        if (auto_gating_select) begin
            applied_mode_next = power_mode_i;
        end
    end

    // Gate set of the applied mode.
    // per-state selection
    always_comb begin
        case (applied_mode_next)
            PCG_MODE_RUN: begin
                gate_en_next = run_gates;
            end
            PCG_MODE_SLEEP: begin
                gate_en_next = slp_gates;
            end
            PCG_MODE_DEEP: begin
                gate_en_next = dsl_gates;
            end
            default: begin
                gate_en_next = run_gates;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------

    // Clock configuration and run-mode gate registers.
    // all gates reset to zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_clock_config_reg <= `PCG_GATE_RST;
            run_gate_ctrl_first_reg <= `PCG_GATE_RST;
            run_gate_ctrl_second_reg <= `PCG_GATE_RST;
        end else begin
            if (wr_cfg) begin
                run_clock_config_reg <= wd_cfg;
            end
            if (wr_run1) begin
                run_gate_ctrl_first_reg <= wd_first;
            end
            if (wr_run2) begin
                run_gate_ctrl_second_reg <= wd_second;
            end
        end
    end

    // Sleep and deep-sleep gate registers.
    // sleep sets reset to zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sleep_gate_ctrl_first_reg <= `PCG_GATE_RST;
            sleep_gate_ctrl_second_reg <= `PCG_GATE_RST;
            deep_sleep_gate_ctrl_first_reg <= `PCG_GATE_RST;
            deep_sleep_gate_ctrl_second_reg <= `PCG_GATE_RST;
        end else begin
            if (wr_slp1) begin
                sleep_gate_ctrl_first_reg <= wd_first;
            end
            if (wr_slp2) begin
                sleep_gate_ctrl_second_reg <= wd_second;
            end
            if (wr_dsl1) begin
                deep_sleep_gate_ctrl_first_reg <= wd_first;
            end
            if (wr_dsl2) begin
                deep_sleep_gate_ctrl_second_reg <= wd_second;
            end
        end
    end

    // ----------------------------------------------------------------
    // Gate enables and gated clocks
    // ----------------------------------------------------------------

    // Registered enables; a unit sees its new gate one edge after the write.
    // enable follows gate
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gate_en_reg <= '0;
            applied_mode_reg <= PCG_MODE_RUN;
        end else begin
            gate_en_reg <= gate_en_next;
            applied_mode_reg <= applied_mode_next;
        end
    end

    // Enables are re-timed on the falling edge while the clock is low, so the
    // AND below can only open or close during a low phase: no runt pulses.
    // glitch-free gating
    always_ff @(negedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gate_lat_reg <= '0;
        end else begin
            gate_lat_reg <= gate_en_reg;
        end
    end

    // One gated clock per unit.
    // clock stopped when gated
    genvar u;
    generate
        for (u = 0; u < `PCG_UNITS; u = u + 1) begin : g_unit_clk
            assign unit_clk_o[u] = clk_i & gate_lat_reg[u];
        end
    endgenerate

    // Units are held disabled while their gate is off.
    // hold unit disabled
    assign unit_en_o = gate_en_reg;

    // ----------------------------------------------------------------
    // Bus fault detection
    // ----------------------------------------------------------------

    // Any selected unit without a clock turns the access into a fault.
    // fault on unclocked unit
    wire fault_hit = unit_access_i && |(unit_sel_i & ~gate_en_reg);
    assign bus_fault_o = fault_hit;

    // ----------------------------------------------------------------
    // Interrupt status
    // ----------------------------------------------------------------

    // Events of this cycle: a bus fault and a change of applied mode.
    wire [`PCG_IRQ_W-1:0] irq_event = {applied_mode_reg != applied_mode_next, fault_hit};

    // Sticky status; a new event wins over a clear in the same cycle.
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (wr_iclr) begin
            irq_stat_next = irq_stat_reg & ~wdata_i[`PCG_IRQ_W-1:0];
        end
        irq_stat_next = irq_stat_next | irq_event;
    end

    // Status and enable storage.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_stat_reg <= '0;
            irq_en_reg <= '0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (wr_ien) begin
                irq_en_reg <= wdata_i[`PCG_IRQ_W-1:0];
            end
        end
    end

    // Level interrupt while any enabled status bit is set.
    assign irq_o = |(irq_stat_reg & irq_en_reg);

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // Read data mux; unmapped and write-only offsets read as zero.
    // reserved bits read zero
    always_comb begin
        rdata_next = '0;
        if (rd_i) begin
            case (addr_i)
                `PCG_OFS_RUN_CFG: begin
                    rdata_next = run_clock_config_reg;
                end
                `PCG_OFS_RUN_FIRST: begin
                    rdata_next = run_gate_ctrl_first_reg;
                end
                `PCG_OFS_RUN_SECOND: begin
                    rdata_next = run_gate_ctrl_second_reg;
                end
                `PCG_OFS_SLP_FIRST: begin
                    rdata_next = sleep_gate_ctrl_first_reg;
                end
                `PCG_OFS_SLP_SECOND: begin
                    rdata_next = sleep_gate_ctrl_second_reg;
                end
                `PCG_OFS_DSL_FIRST: begin
                    rdata_next = deep_sleep_gate_ctrl_first_reg;
                end
                `PCG_OFS_DSL_SECOND: begin
                    rdata_next = deep_sleep_gate_ctrl_second_reg;
                end
                `PCG_OFS_IRQ_STAT: begin
                    rdata_next = {30'h0, irq_stat_reg};
                end
                `PCG_OFS_IRQ_EN: begin
                    rdata_next = {30'h0, irq_en_reg};
                end
                `PCG_OFS_GATE_STAT: begin
                    rdata_next = {17'h0, applied_mode_reg, gate_en_reg};
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    // Read data stand for exactly the cycle after the strobe.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;

endmodule // pcg_top
`default_nettype wire

//--- tb/pcg_checker.sv
// Concurrent port checks of the clock gating block.
`include "pcg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pcg_checker import pcg_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [`PCG_ADDR_W-1:0] addr_i,
    input wire pcg_pkg::pcg_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire pcg_pkg::pcg_word_t rdata_o,
    input wire pcg_pkg::pcg_mode_e power_mode_i,
    input wire logic [`PCG_UNITS-1:0] unit_sel_i,
    input wire logic unit_access_i,
    input wire logic bus_fault_o,
    input wire logic [`PCG_UNITS-1:0] unit_en_o,
    input wire logic [`PCG_UNITS-1:0] unit_clk_o,
    input wire logic irq_o
);
    // ----------------------------------------------------------------
    // Port relations
    // ----------------------------------------------------------------
    // All checks sample on the rising edge except a_clk_from_enable, which samples on the falling edge; all rest while reset is low.
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_fault_on_gated: assert property (
        unit_access_i |-> bus_fault_o == |(unit_sel_i & ~unit_en_o))
        else $error("bus fault does not match gated selection");
    a_rdata_one_cycle: assert property (
        !$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data present outside read cycle");
    a_run_reserved_zero: assert property (
        rd_i && addr_i == `PCG_OFS_RUN_SECOND |=> (rdata_o & ~`PCG_SECOND_MASK) == 32'h0)
        else $error("reserved run bits read nonzero");
    a_deep_reserved_zero: assert property (
        rd_i && addr_i == `PCG_OFS_DSL_FIRST |=> (rdata_o & ~`PCG_FIRST_MASK) == 32'h0)
        else $error("reserved deep bits read nonzero");
    // The gated clock high phase carries the enable latched on the last falling edge.
    a_clk_from_enable: assert property (
        @(negedge clk_i) unit_clk_o == $past(unit_en_o))
        else $error("gated clock disagrees with enable");
    // The write lands on one edge and reaches the enables on the next one.
    a_run_write_applies: assert property (
        wr_i && addr_i == `PCG_OFS_RUN_SECOND && power_mode_i == PCG_MODE_RUN
        ##1 power_mode_i == PCG_MODE_RUN && !(wr_i && addr_i == `PCG_OFS_RUN_SECOND)
        |=> unit_en_o[8:0] == {$past(wdata_i[30], 2), $past(wdata_i[28], 2),
                               $past(wdata_i[6:0], 2)})
        else $error("run write not applied to enables");
    a_en_steady: assert property (
        !wr_i && !$past(wr_i) && $stable(power_mode_i) |=> $stable(unit_en_o))
        else $error("enables moved without cause");
    a_irq_cleared: assert property (
        wr_i && addr_i == `PCG_OFS_IRQ_CLR && wdata_i == 32'h3 && !unit_access_i
        && !$past(wr_i) && $stable(power_mode_i) |=> !irq_o)
        else $error("interrupt still high after clear");
endmodule // pcg_checker

bind pcg_top pcg_checker u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .power_mode_i(power_mode_i), .unit_sel_i(unit_sel_i), .unit_access_i(unit_access_i),
    .bus_fault_o(bus_fault_o), .unit_en_o(unit_en_o), .unit_clk_o(unit_clk_o), .irq_o(irq_o));
`default_nettype wire

//--- tb/pcg_periph_model.sv
// Behavioural model of the peripheral units fed by gated clocks.
`timescale 1ns/1ps
`default_nettype none
module pcg_periph_model (
    input wire logic [12:0] unit_clk_i,
    input wire logic clr_i,
    output logic [12:0] seen_o
);
    // ----------------------------------------------------------------
    // Clock activity capture
    // ----------------------------------------------------------------
    // units run clocked
    // Each unit notes any rising clock edge it receives since the last clear.
    for (genvar k = 0; k < 13; k++) begin : g_unit
        always @(posedge unit_clk_i[k] or posedge clr_i) begin
            if (clr_i) begin
                seen_o[k] <= 1'b0;
            end else begin
                seen_o[k] <= 1'b1;
            end
        end
    end
endmodule // pcg_periph_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench of the clock gating block.
`include "pcg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pcg_pkg::*;
    logic clk_i, rst_b_i, wr_i, rd_i, unit_access_i, clr, bus_fault_o, irq_o;
    logic [11:0] addr_i;
    pcg_word_t wdata_i, rdata_o;
    pcg_mode_e power_mode_i;
    logic [12:0] unit_sel_i, unit_en_o, unit_clk_o, seen;
    int failures, n_compared, cyc;

    pcg_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .power_mode_i(power_mode_i),
        .unit_sel_i(unit_sel_i), .unit_access_i(unit_access_i), .bus_fault_o(bus_fault_o),
        .unit_en_o(unit_en_o), .unit_clk_o(unit_clk_o), .irq_o(irq_o));
    pcg_periph_model peer (.unit_clk_i(unit_clk_o), .clr_i(clr), .seen_o(seen));

    // Free running system clock.
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // One-cycle write; ends just after the edge that takes it.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    // One-cycle read; data is judged in the cycle after the strobe.
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(n, e, rdata_o);
    endtask

    // A register write reaches the unit enables one edge after it lands.
    task automatic settle();
        @(posedge clk_i);
        #1;
    endtask

    task automatic set_mode(input pcg_mode_e m);
        @(posedge clk_i);
        power_mode_i <= m;
        @(posedge clk_i);
        #1;
    endtask

    // Clears the unit activity record and compares it after a few cycles.
    task automatic t_clk(input logic [12:0] e);
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        chk("unit_clocks", e, seen);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk("unit_en", 32'h0, unit_en_o);
        rd(`PCG_OFS_RUN_SECOND, 32'h0, "run_second");
        rd(`PCG_OFS_DSL_FIRST, 32'h0, "deep_first");
        rd(12'h200, 32'h0, "unmapped");
        t_clk(13'h0000);
    endtask

    // Walks each gate bit of the run-mode second gate register alone, then all its bits with reserved ones set.
    task automatic t_run();
        int b [9] = '{0, 1, 2, 3, 4, 5, 6, 28, 30};
        for (int k = 0; k < 9; k++) begin
            wr(`PCG_OFS_RUN_SECOND, 32'h1 << b[k]);
            settle();
            chk("unit_en", 32'h1 << k, unit_en_o);
        end
        wr(`PCG_OFS_RUN_SECOND, 32'hffffffff);
        rd(`PCG_OFS_RUN_SECOND, 32'h5000007f, "run_second");
        t_clk(13'h01ff);
    endtask

    task automatic t_fault();
        wr(`PCG_OFS_RUN_SECOND, 32'h5000007e);
        @(posedge clk_i);
        unit_sel_i <= 13'h0001;
        unit_access_i <= 1'b1;
        #1;
        chk("bus_fault", 32'h1, bus_fault_o);
        @(posedge clk_i);
        unit_sel_i <= 13'h0002;
        #1;
        chk("bus_fault", 32'h0, bus_fault_o);
        @(posedge clk_i);
        unit_access_i <= 1'b0;
        wr(`PCG_OFS_IRQ_EN, 32'h1);
        chk("irq", 32'h1, irq_o);
        wr(`PCG_OFS_IRQ_CLR, 32'h3);
        chk("irq", 32'h0, irq_o);
    endtask

    task automatic t_modes();
        wr(`PCG_OFS_DSL_FIRST, 32'hffffffff);
        rd(`PCG_OFS_DSL_FIRST, 32'h00001013, "deep_first");
        wr(`PCG_OFS_SLP_SECOND, 32'h10000001);
        set_mode(PCG_MODE_DEEP);
        chk("unit_en", 32'h01fe, unit_en_o);
        wr(`PCG_OFS_RUN_CFG, 32'h1);
        settle();
        chk("unit_en", 32'h1e00, unit_en_o);
        t_clk(13'h1e00);
        set_mode(PCG_MODE_SLEEP);
        chk("unit_en", 32'h0081, unit_en_o);
        set_mode(PCG_MODE_RUN);
        chk("unit_en", 32'h01fe, unit_en_o);
        rd(`PCG_OFS_GATE_STAT, 32'h000001fe, "gate_stat");
        rd(`PCG_OFS_IRQ_STAT, 32'h00000002, "irq_stat");
    endtask

    // Cuts a hang short well beyond the expected run length.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            print_verdict();
        end
    end

    // Main sequence: reset for three cycles, then each scenario in turn.
    initial begin
        rst_b_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 12'h000;
        wdata_i = 32'h0;
        power_mode_i = PCG_MODE_RUN;
        unit_sel_i = 13'h0000;
        unit_access_i = 1'b0;
        clr = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_run();
        t_fault();
        t_modes();
        print_verdict();
    end
endmodule // tb
`default_nettype wire
